// >>> hw/pcx_ext_regs.sv
// Extended register array reached only through the indirect access path.
`timescale 1ns/1ns
module pcx_ext_regs (
   // Clock and reset
   input wire logic   clk_i,
   input wire logic   rst_n_i,
   // Access port
   pcx_ext_if.regs    ext
);
   logic [15:0] mem_q [pcx_pkg::EXT_DEPTH];
   wire         in_range;

   assign in_range  = (ext.addr >= pcx_pkg::EXT_LOW) &&
                      (ext.addr < pcx_pkg::EXT_END);
   assign ext.rdata = in_range ? mem_q[ext.addr[7:0]] : 16'h0000;

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         for (int i = 0; i < pcx_pkg::EXT_DEPTH; i++) begin
            mem_q[i] <= 16'h0000;
         end
      end else if (ext.we && in_range) begin
         mem_q[ext.addr[7:0]] <= ext.wdata;
      end
   end
endmodule

// >>> hw/pcx_fld_count.sv
// Counts events inside the current window and flags the threshold hit.
`timescale 1ns/1ns
module pcx_fld_count #(
   parameter logic [5:0] THRESH = 6'h14
) (
   // Clock and reset
   input wire logic  clk_i,
   input wire logic  rst_n_i,
   // Control and events
   input wire logic  en_i,
   input wire logic  evt_i,
   input wire logic  win_tick_i,
   // Result
   output logic      hit_o
);
   logic [5:0] cnt_q;
   logic [5:0] cnt_d;

   assign hit_o = en_i && evt_i && (cnt_q == 6'(THRESH - 6'h01));
   assign cnt_d = (!en_i || win_tick_i || hit_o) ? 6'h00 :
                  evt_i ? 6'(cnt_q + 6'h01) : cnt_q;

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         cnt_q <= 6'h00;
      end else begin
         cnt_q <= cnt_d;
      end
   end
endmodule

// >>> hw/pcx_top.sv
// Management registers for pair control, fast link drop and indirect access.
// Functional notes
// - Control register three bits 15 to 7 read zero and ignore writes.
// - Bit 6 set inverts polarity of both transmit and receive pairs.
// - Bit 5 set swaps pair roles: receive on transmit pair, vice versa.
// - Port mirroring is active only when bits 5 and 6 are both set.
// - Bit 3 drops link after 32 receive errors within 10 us.
// - Bit 2 drops link after 20 line code violations within 10 us.
// - Bit 1 drops link after 20 low signal to noise crossings in 10 us.
// - Bit 0 drops link when the energy detector reports energy loss.
// - Link drop is the OR of all enabled conditions in bits 3 to 0.
// - Extended registers above 0x1F are reached only through 0x0D and 0x0E.
// - Function 00 makes a data register write load the extended pointer.
// - Function 01 accesses the pointed register and leaves the pointer.
// - Function 10 accesses then increments the pointer on reads and writes.
// - Function 11 increments the pointer after writes only, never reads.
// - Indirect accesses with a device select other than 11111 are ignored.
// - Data register is 16 bits: pointer in function 00, else data.
`timescale 1ns/1ns
module pcx_top #(
   parameter logic [4:0] PHY_ADDR = 5'h01
) (
   // Clock and reset
   input wire logic   CLK_I,
   input wire logic   RESETN_I,
   // Serial management pins
   input wire logic   MDC_I,
   input wire logic   MDIO_I,
   output logic       MDIO_O,
   output logic       MDIO_OE_N_O,
   // Datapath event inputs
   input wire logic   RX_ERR_EVT_I,
   input wire logic   CODE_VIOL_EVT_I,
   input wire logic   LOW_SNR_EVT_I,
   input wire logic   ENERGY_LOSS_I,
   // Pair and link controls
   output logic       POL_INV_O,
   output logic       PAIR_SWAP_O,
   output logic       MIRROR_EN_O,
   output logic       LINK_DROP_O
);
   function automatic logic [15:0] ptr_inc(input logic [15:0] p);
      ptr_inc = 16'(p + 16'h0001);
   endfunction

   logic                rst_meta_q;
   logic                rst_n;
   logic                mdc_s1_q;
   logic                mdc_s2_q;
   logic                mdc_s3_q;
   logic                mdio_s1_q;
   logic                mdio_s2_q;
   logic                mdio_s3_q;

   pcx_pkg::pcx_state_t state_q;
   logic [5:0]          pre_q;
   logic [3:0]          bit_q;
   logic [4:0]          cnt_q;
   logic [13:0]         hdr_q;
   logic [15:0]         dsh_q;
   logic                rd_q;
   logic [4:0]          reg_q;

   logic [6:0]          c3_q;
   logic [1:0]          func_q;
   logic [4:0]          dev_q;
   logic [15:0]         ptr_q;
   logic [7:0]          win_q;
   logic                mirror_q;
   logic                drop_q;
   logic                mdo_q;
   logic                oe_n_q;

   wire                 rise;
   wire                 sbit;
   wire [13:0]          hdr_nx;
   wire                 hdr_ok;
   wire [15:0]          rd_mux;
   wire                 dev_ok;
   wire                 done;
   wire                 wr_done;
   wire                 rd_done;
   wire [15:0]          wr_data;
   wire                 hit_rx;
   wire                 hit_cv;
   wire                 hit_snr;
   wire                 win_tick;
   wire                 drop_d;

   pcx_ext_if ext_bus ();

   // Reset release and pin synchronisers.
   always_ff @(posedge CLK_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         rst_meta_q <= 1'b0;
         rst_n      <= 1'b0;
      end else begin
         rst_meta_q <= 1'b1;
         rst_n      <= rst_meta_q;
      end
   end

   always_ff @(posedge CLK_I or negedge rst_n) begin
      if (!rst_n) begin
         mdc_s1_q  <= 1'b0;
         mdc_s2_q  <= 1'b0;
         mdc_s3_q  <= 1'b0;
         mdio_s1_q <= 1'b1;
         mdio_s2_q <= 1'b1;
         mdio_s3_q <= 1'b1;
      end else begin
         mdc_s1_q  <= MDC_I;
         mdc_s2_q  <= mdc_s1_q;
         mdc_s3_q  <= mdc_s2_q;
         mdio_s1_q <= MDIO_I;
         mdio_s2_q <= mdio_s1_q;
         mdio_s3_q <= mdio_s2_q;
      end
   end

   // Frame decode: start 01, opcode, device address, register address.
   assign rise    = mdc_s2_q && !mdc_s3_q;
   assign sbit    = mdio_s3_q;
   assign hdr_nx  = {hdr_q[12:0], sbit};
   assign hdr_ok  = (hdr_nx[13:12] == pcx_pkg::MD_START) &&
                    (hdr_nx[9:5] == PHY_ADDR) &&
                    ((hdr_nx[11:10] == pcx_pkg::MD_OP_RD) ||
                     (hdr_nx[11:10] == pcx_pkg::MD_OP_WR));
   assign dev_ok  = (dev_q == pcx_pkg::DEV_SEL_OK);
   assign done    = rise && (state_q == pcx_pkg::ST_DAT) &&
                    (cnt_q == pcx_pkg::DAT_LAST);
   assign wr_done = done && !rd_q;
   assign rd_done = done && rd_q;
   assign wr_data = {dsh_q[14:0], sbit};

   // Read selection; only three addresses are mapped, the rest read zero.
   assign rd_mux =
      (hdr_nx[4:0] == pcx_pkg::ADR_CTRL3) ? {9'h000, c3_q} :
      (hdr_nx[4:0] == pcx_pkg::ADR_IACC)  ? {func_q, 9'h000, dev_q} :
      (hdr_nx[4:0] == pcx_pkg::ADR_IADDR) ?
         (!dev_ok ? 16'h0000 :
          (func_q == pcx_pkg::FN_ADDR) ? ptr_q : ext_bus.rdata) :
      16'h0000;

   // Extended array access through the pointer.
   assign ext_bus.addr  = ptr_q;
   assign ext_bus.wdata = wr_data;
   assign ext_bus.we    = wr_done && (reg_q == pcx_pkg::ADR_IADDR) &&
                          dev_ok && (func_q != pcx_pkg::FN_ADDR);

   pcx_ext_regs u_ext (
      .clk_i   (CLK_I),
      .rst_n_i (rst_n),
      .ext     (ext_bus)
   );

   always_ff @(posedge CLK_I or negedge rst_n) begin
      if (!rst_n) begin
         state_q <= pcx_pkg::ST_PRE;
         pre_q   <= 6'h00;
         bit_q   <= 4'h0;
         cnt_q   <= 5'h00;
         hdr_q   <= 14'h0000;
         dsh_q   <= 16'h0000;
         rd_q    <= 1'b0;
         reg_q   <= 5'h00;
         mdo_q   <= 1'b1;
         oe_n_q  <= 1'b1;
      end else if (rise) begin
         unique case (state_q)
            pcx_pkg::ST_PRE: begin
               if (sbit) begin
                  if (pre_q != pcx_pkg::PRE_BITS) begin
                     pre_q <= 6'(pre_q + 6'h01);
                  end
               end else if (pre_q == pcx_pkg::PRE_BITS) begin
                  state_q <= pcx_pkg::ST_HDR;
                  hdr_q   <= 14'h0000;
                  bit_q   <= 4'h1;
               end else begin
                  pre_q <= 6'h00;
               end
            end
            pcx_pkg::ST_HDR: begin
               hdr_q <= hdr_nx;
               bit_q <= 4'(bit_q + 4'h1);
               if (bit_q == pcx_pkg::HDR_LAST) begin
                  pre_q   <= 6'h00;
                  rd_q    <= (hdr_nx[11:10] == pcx_pkg::MD_OP_RD);
                  reg_q   <= hdr_nx[4:0];
                  dsh_q   <= rd_mux;
                  state_q <= hdr_ok ? pcx_pkg::ST_TA : pcx_pkg::ST_PRE;
               end
            end
            pcx_pkg::ST_TA: begin
               mdo_q   <= 1'b0;
               oe_n_q  <= !rd_q;
               cnt_q   <= 5'h00;
               state_q <= pcx_pkg::ST_DAT;
            end
            pcx_pkg::ST_DAT: begin
               dsh_q <= {dsh_q[14:0], sbit};
               mdo_q <= dsh_q[15];
               cnt_q <= 5'(cnt_q + 5'h01);
               if (cnt_q == pcx_pkg::DAT_LAST) begin
                  mdo_q   <= 1'b1;
                  oe_n_q  <= 1'b1;
                  state_q <= pcx_pkg::ST_PRE;
               end
            end
            default: begin
               state_q <= pcx_pkg::ST_PRE;
               oe_n_q  <= 1'b1;
            end
         endcase
      end
   end

   // Register writes and pointer updates.
   always_ff @(posedge CLK_I or negedge rst_n) begin
      if (!rst_n) begin
         c3_q   <= pcx_pkg::C3_RESET;
         func_q <= pcx_pkg::FN_ADDR;
         dev_q  <= pcx_pkg::DEV_RESET;
         ptr_q  <= pcx_pkg::PTR_RESET;
      end else if (wr_done) begin
         if (reg_q == pcx_pkg::ADR_CTRL3) begin
            c3_q <= wr_data[6:0];
         end
         if (reg_q == pcx_pkg::ADR_IACC) begin
            func_q <= wr_data[pcx_pkg::IA_FN_HI:pcx_pkg::IA_FN_LO];
            dev_q  <= wr_data[4:0];
         end
         if ((reg_q == pcx_pkg::ADR_IADDR) && dev_ok) begin
            if (func_q == pcx_pkg::FN_ADDR) begin
               ptr_q <= wr_data;
            end else if ((func_q == pcx_pkg::FN_INC_RW) ||
                         (func_q == pcx_pkg::FN_INC_WR)) begin
               ptr_q <= ptr_inc(ptr_q);
            end
         end
      end else if (rd_done && (reg_q == pcx_pkg::ADR_IADDR) && dev_ok &&
                   (func_q == pcx_pkg::FN_INC_RW)) begin
         ptr_q <= ptr_inc(ptr_q);
      end
   end

   // Window timing and fast link drop.
   assign win_tick = (win_q == pcx_pkg::WIN_LAST);

   pcx_fld_count #(.THRESH(pcx_pkg::RXERR_THRESH)) u_rx (
      .clk_i      (CLK_I),
      .rst_n_i    (rst_n),
      .en_i       (c3_q[pcx_pkg::C3_FLD_RX]),
      .evt_i      (RX_ERR_EVT_I),
      .win_tick_i (win_tick),
      .hit_o      (hit_rx)
   );

   pcx_fld_count #(.THRESH(pcx_pkg::CVIOL_THRESH)) u_cv (
      .clk_i      (CLK_I),
      .rst_n_i    (rst_n),
      .en_i       (c3_q[pcx_pkg::C3_FLD_CV]),
      .evt_i      (CODE_VIOL_EVT_I),
      .win_tick_i (win_tick),
      .hit_o      (hit_cv)
   );

   pcx_fld_count #(.THRESH(pcx_pkg::LSNR_THRESH)) u_snr (
      .clk_i      (CLK_I),
      .rst_n_i    (rst_n),
      .en_i       (c3_q[pcx_pkg::C3_FLD_SNR]),
      .evt_i      (LOW_SNR_EVT_I),
      .win_tick_i (win_tick),
      .hit_o      (hit_snr)
   );

   assign drop_d = hit_rx || hit_cv || hit_snr ||
                   (c3_q[pcx_pkg::C3_FLD_EN] && ENERGY_LOSS_I);

   always_ff @(posedge CLK_I or negedge rst_n) begin
      if (!rst_n) begin
         win_q    <= 8'h00;
         mirror_q <= 1'b0;
         drop_q   <= 1'b0;
      end else begin
         win_q    <= win_tick ? 8'h00 : 8'(win_q + 8'h01);
         mirror_q <= c3_q[pcx_pkg::C3_POL] && c3_q[pcx_pkg::C3_SWAP];
         drop_q   <= drop_d;
      end
   end

   assign POL_INV_O   = c3_q[pcx_pkg::C3_POL];
   assign PAIR_SWAP_O = c3_q[pcx_pkg::C3_SWAP];
   assign MIRROR_EN_O = mirror_q;
   assign LINK_DROP_O = drop_q;
   assign MDIO_O      = mdo_q;
   assign MDIO_OE_N_O = oe_n_q;
endmodule

// >>> inc/pcx_ext_if.sv
// Access port between the management logic and the extended register array.
`timescale 1ns/1ns
interface pcx_ext_if;
   logic        we;
   logic [15:0] addr;
   logic [15:0] wdata;
   logic [15:0] rdata;

   modport host (output we, output addr, output wdata, input rdata);
   modport regs (input we, input addr, input wdata, output rdata);
endinterface

// >>> inc/pcx_pkg.sv
// Shared constants and types for the pair control and indirect access block.
package pcx_pkg;
   localparam int          CLK_HZ       = 20_000_000;
   localparam int          WIN_NS       = 10_000;
   localparam int          WIN_CYC      = (WIN_NS * (CLK_HZ / 1_000_000)) / 1000;
   localparam logic [7:0]  WIN_LAST     = 8'(WIN_CYC - 1);

   localparam logic [5:0]  RXERR_THRESH = 6'h20;
   localparam logic [5:0]  CVIOL_THRESH = 6'h14;
   localparam logic [5:0]  LSNR_THRESH  = 6'h14;

   localparam logic [4:0]  ADR_CTRL3    = 5'h0B;
   localparam logic [4:0]  ADR_IACC     = 5'h0D;
   localparam logic [4:0]  ADR_IADDR    = 5'h0E;
   localparam logic [15:0] EXT_LOW      = 16'h0020;
   localparam logic [15:0] EXT_END      = 16'h0100;
   localparam int          EXT_DEPTH    = 256;

   localparam int          C3_POL       = 6;
   localparam int          C3_SWAP      = 5;
   localparam int          C3_FLD_RX    = 3;
   localparam int          C3_FLD_CV    = 2;
   localparam int          C3_FLD_SNR   = 1;
   localparam int          C3_FLD_EN    = 0;
   localparam logic [6:0]  C3_RESET     = 7'h00;

   localparam int          IA_FN_HI     = 15;
   localparam int          IA_FN_LO     = 14;
   localparam logic [4:0]  DEV_SEL_OK   = 5'h1F;
   localparam logic [4:0]  DEV_RESET    = 5'h00;
   localparam logic [15:0] PTR_RESET    = 16'h0000;

   localparam logic [5:0]  PRE_BITS     = 6'h20;
   localparam logic [3:0]  HDR_LAST     = 4'hD;
   localparam logic [4:0]  DAT_LAST     = 5'h10;
   localparam logic [1:0]  MD_START     = 2'h1;
   localparam logic [1:0]  MD_OP_RD     = 2'h2;
   localparam logic [1:0]  MD_OP_WR     = 2'h1;

   typedef enum logic [1:0] {
      FN_ADDR   = 2'h0,
      FN_DATA   = 2'h1,
      FN_INC_RW = 2'h2,
      FN_INC_WR = 2'h3
   } pcx_func_t;

   typedef enum logic [3:0] {
      ST_PRE = 4'h1,
      ST_HDR = 4'h2,
      ST_TA  = 4'h4,
      ST_DAT = 4'h8
   } pcx_state_t;
endpackage

// >>> sim/pcx_mdio_host.sv
// Station management host model that drives frames on the serial pins.
`timescale 1ns/1ns
module pcx_mdio_host (
   // Clock
   input wire logic    clk_i,
   // Serial pins
   input wire logic    mdio_i,
   output logic        mdc_o,
   output logic        mdio_o,
   // Read result
   output logic        done_o,
   output logic [15:0] data_o
);
   initial begin
      mdc_o = 1'b0;
      mdio_o = 1'b1;
      done_o = 1'b0;
      data_o = 16'h0000;
   end

   // Data is set while the clock is low and sampled at its rise.
   task automatic bit_io(input logic b, output logic s);
      mdio_o <= b;
      repeat (4) @(posedge clk_i);
      s = mdio_i;
      mdc_o <= 1'b1;
      repeat (4) @(posedge clk_i);
      mdc_o <= 1'b0;
   endtask

   // A released line shows one, as the pull-up makes it.
   task automatic frame(input logic rd, input logic [4:0] phy,
                        input logic [4:0] ra, input logic [15:0] wd);
      logic [47:0] hdr;
      logic [15:0] r;
      logic        s;
      hdr = {32'hFFFFFFFF, 2'h1, rd, ~rd, phy, ra, 1'b1, rd};
      for (int i = 47; i >= 0; i--) bit_io(hdr[i], s);
      for (int i = 15; i >= 0; i--) begin
         bit_io(rd | wd[i], s);
         r[i] = s;
      end
      if (rd) begin
         data_o <= r;
         done_o <= 1'b1;
         @(posedge clk_i);
         done_o <= 1'b0;
      end
   endtask
endmodule

// >>> sim/pcx_top_properties.sv
// Checker for pair controls, fast link drop and management read timing.
`timescale 1ns/1ns
module pcx_top_properties (
   // Clock and reset
   input wire logic CLK_I,
   input wire logic RESETN_I,
   // Serial management pins
   input wire logic MDC_I,
   input wire logic MDIO_O,
   input wire logic MDIO_OE_N_O,
   // Datapath events
   input wire logic RX_ERR_EVT_I,
   input wire logic CODE_VIOL_EVT_I,
   input wire logic LOW_SNR_EVT_I,
   input wire logic ENERGY_LOSS_I,
   // Pair and link controls
   input wire logic POL_INV_O,
   input wire logic PAIR_SWAP_O,
   input wire logic MIRROR_EN_O,
   input wire logic LINK_DROP_O
);
   logic [203:0] rx_q;
   logic [203:0] cv_q;
   logic [203:0] sn_q;
   logic [2:0]   en_q;
   logic         mdc_q;
   logic [7:0]   since_q;
   logic [5:0]   rise_q;
   wire          mdc_up = MDC_I & ~mdc_q;
   wire          en_seen = |en_q;
   wire          hit = ($countones(rx_q) >= pcx_pkg::RXERR_THRESH) ||
                       ($countones(cv_q) >= pcx_pkg::CVIOL_THRESH) ||
                       ($countones(sn_q) >= pcx_pkg::LSNR_THRESH);

   // Sliding event history is a superset of any fixed window.
   always_ff @(posedge CLK_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         rx_q    <= '0;
         cv_q    <= '0;
         sn_q    <= '0;
         en_q    <= 3'h0;
         mdc_q   <= 1'b0;
         since_q <= 8'hFF;
         rise_q  <= 6'h00;
      end else begin
         rx_q    <= {rx_q[202:0], RX_ERR_EVT_I};
         cv_q    <= {cv_q[202:0], CODE_VIOL_EVT_I};
         sn_q    <= {sn_q[202:0], LOW_SNR_EVT_I};
         en_q    <= {en_q[1:0], ENERGY_LOSS_I};
         mdc_q   <= MDC_I;
         since_q <= mdc_up ? 8'h00 : since_q + {7'h00, since_q != 8'hFF};
         rise_q  <= MDIO_OE_N_O ? 6'h00 : rise_q + {5'h00, mdc_up};
      end
   end

   default clocking cb @(posedge CLK_I); endclocking
   default disable iff (!RESETN_I);

   mirror_follow_a: assert property (
      MIRROR_EN_O == $past(POL_INV_O & PAIR_SWAP_O))
      else $error("mirror enable differs from polarity and swap");
   pol_by_mgmt_a: assert property (
      $changed(POL_INV_O) |-> since_q < 8'h0C)
      else $error("polarity changed without a management write");
   swap_by_mgmt_a: assert property (
      $changed(PAIR_SWAP_O) |-> since_q < 8'h0C)
      else $error("pair swap changed without a management write");
   drop_cause_a: assert property (
      LINK_DROP_O |-> en_seen || hit)
      else $error("link drop without energy loss or count hit");
   drop_pulse_a: assert property (
      LINK_DROP_O && !en_seen |=> !LINK_DROP_O || en_seen)
      else $error("count link drop longer than one cycle");
   energy_level_a: assert property (
      ENERGY_LOSS_I && en_q[0] && LINK_DROP_O |=> LINK_DROP_O)
      else $error("link drop fell while energy still lost");
   ta_zero_a: assert property (
      $fell(MDIO_OE_N_O) |-> !MDIO_O)
      else $error("turnaround bit not driven low");
   read_len_a: assert property (
      $rose(MDIO_OE_N_O) |-> rise_q == 6'h11)
      else $error("read drive not seventeen clock periods");
endmodule

bind pcx_top pcx_top_properties chk_u (
   .CLK_I(CLK_I), .RESETN_I(RESETN_I), .MDC_I(MDC_I), .MDIO_O(MDIO_O),
   .MDIO_OE_N_O(MDIO_OE_N_O), .RX_ERR_EVT_I(RX_ERR_EVT_I),
   .CODE_VIOL_EVT_I(CODE_VIOL_EVT_I), .LOW_SNR_EVT_I(LOW_SNR_EVT_I),
   .ENERGY_LOSS_I(ENERGY_LOSS_I), .POL_INV_O(POL_INV_O),
   .PAIR_SWAP_O(PAIR_SWAP_O), .MIRROR_EN_O(MIRROR_EN_O),
   .LINK_DROP_O(LINK_DROP_O));

// >>> sim/phy_ctrl3_and_indirect_access_bench.sv
// Self-checking bench for pair control, link drop and indirect access.
`timescale 1ns/1ns
module phy_ctrl3_and_indirect_access_bench;
   localparam logic [4:0] PHY = 5'h05;
   localparam logic [4:0] C3  = pcx_pkg::ADR_CTRL3;
   localparam logic [4:0] IA  = pcx_pkg::ADR_IACC;
   localparam logic [4:0] ID  = pcx_pkg::ADR_IADDR;
   logic        clk;
   logic        rst_n;
   logic [2:0]  ev;
   logic        energy;
   logic        mdc;
   logic        mdio_h;
   logic        mdio_d;
   logic        oe_n;
   logic        pol;
   logic        swap;
   logic        mir;
   logic        drop;
   logic        done;
   logic [15:0] rdata;
   logic [15:0] exp_q[$];
   logic [15:0] a;
   logic [15:0] b;
   logic [15:0] c;
   logic [5:0]  thr[3];
   int          num_errors;
   int          compares;
   int          drops;
   int          cyc;
   integer      seed;
   wire         mdio_line = oe_n ? mdio_h : mdio_d;

   pcx_top #(.PHY_ADDR(PHY)) dut (
      .CLK_I(clk), .RESETN_I(rst_n), .MDC_I(mdc), .MDIO_I(mdio_line),
      .MDIO_O(mdio_d), .MDIO_OE_N_O(oe_n), .RX_ERR_EVT_I(ev[0]),
      .CODE_VIOL_EVT_I(ev[1]), .LOW_SNR_EVT_I(ev[2]),
      .ENERGY_LOSS_I(energy), .POL_INV_O(pol), .PAIR_SWAP_O(swap),
      .MIRROR_EN_O(mir), .LINK_DROP_O(drop));
   pcx_mdio_host host (
      .clk_i(clk), .mdio_i(mdio_line), .mdc_o(mdc), .mdio_o(mdio_h),
      .done_o(done), .data_o(rdata));

   task automatic chk(input string n, input logic [15:0] s,
                      input logic [15:0] e);
      compares++;
      if (s !== e) begin
         num_errors++;
         $display("mismatch %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic wr(input logic [4:0] ra, input logic [15:0] d);
      host.frame(1'b0, PHY, ra, d);
   endtask
   task automatic rd(input logic [4:0] ra, input logic [15:0] e);
      exp_q.push_back(e);
      host.frame(1'b1, PHY, ra, 16'h0000);
   endtask
   task automatic ptr(input logic [15:0] f, input logic [15:0] p);
      wr(IA, 16'h001F);
      wr(ID, p);
      wr(IA, f);
   endtask
   task automatic pulse(input logic [2:0] m, input int n);
      repeat (n) begin
         ev <= m;
         @(posedge clk);
         ev <= 3'h0;
         @(posedge clk);
      end
   endtask
   task automatic end_of_test;
      $display("compares %0d num_errors %0d", compares, num_errors);
      if (num_errors == 0 && compares > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   always #25 clk = ~clk;

   // Read results are matched against the oldest noted value.
   always @(posedge clk) begin
      cyc++;
      if (done === 1'b1) chk("read data", rdata, exp_q.pop_front());
      if (drop === 1'b1) drops++;
      if (cyc == 80000) begin
         num_errors++;
         end_of_test;
      end
   end

   initial begin
      clk = 1'b0;
      rst_n = 1'b0;
      ev = 3'h0;
      energy = 1'b0;
      seed = 32'h7e9d;
      thr = '{pcx_pkg::RXERR_THRESH, pcx_pkg::CVIOL_THRESH,
              pcx_pkg::LSNR_THRESH};
      repeat (20) @(posedge clk);
      rst_n <= 1'b1;
      repeat (5) @(posedge clk);
      rd(C3, 16'h0000);
      rd(IA, 16'h0000);
      rd(ID, 16'h0000);
      wr(C3, 16'hFFFF);
      rd(C3, 16'h007F);
      wr(IA, 16'hFFFF);
      rd(IA, 16'hC01F);
      rd(5'h1C, 16'h0000);
      host.frame(1'b0, 5'h06, C3, 16'h0000);
      rd(C3, 16'h007F);
      for (int i = 0; i < 4; i++) begin
         wr(C3, 16'(i << 5));
         repeat (10) @(posedge clk);
         chk("polarity", {15'h0000, pol}, 16'(i >> 1));
         chk("pair swap", {15'h0000, swap}, 16'(i & 1));
         chk("mirror", {15'h0000, mir}, 16'(i == 3));
      end
      a = 16'($random(seed));
      b = 16'($random(seed));
      c = 16'($random(seed));
      ptr(16'h401F, 16'h0040);
      wr(ID, a);
      rd(ID, a);
      rd(ID, a);
      wr(IA, 16'h801F);
      wr(ID, b);
      wr(ID, c);
      ptr(16'h801F, 16'h0040);
      rd(ID, b);
      rd(ID, c);
      ptr(16'hC01F, 16'h0040);
      rd(ID, b);
      wr(ID, a);
      rd(ID, c);
      wr(IA, 16'h4001);
      rd(ID, 16'h0000);
      wr(ID, b);
      wr(IA, 16'h401F);
      rd(ID, c);
      ptr(16'h801F, 16'hFFFF);
      wr(ID, a);
      wr(IA, 16'h001F);
      rd(ID, 16'h0000);
      for (int s = 0; s < 3; s++) begin
         wr(C3, 16'h000E ^ (16'h0008 >> s));
         drops = 0;
         pulse(3'h1 << s, 200);
         chk("drop disabled", 16'(drops), 16'h0000);
         wr(C3, 16'h0008 >> s);
         drops = 0;
         pulse(3'h1 << s, thr[s] - 1);
         repeat (250) @(posedge clk);
         chk("drop early", 16'(drops), 16'h0000);
         pulse(3'h1 << s, 200);
         chk("drop seen", 16'(drops > 0), 16'h0001);
      end
      wr(C3, 16'h000E);
      energy <= 1'b1;
      repeat (10) @(posedge clk);
      chk("energy off", {15'h0000, drop}, 16'h0000);
      wr(C3, 16'h0001);
      repeat (10) @(posedge clk);
      chk("energy on", {15'h0000, drop}, 16'h0001);
      energy <= 1'b0;
      repeat (5) @(posedge clk);
      chk("energy gone", {15'h0000, drop}, 16'h0000);
      repeat (5) @(posedge clk);
      end_of_test;
   end
endmodule
